// ==== src/uefd_params.svh ====
`ifndef UEFD_PARAMS_SVH
`define UEFD_PARAMS_SVH
`define UEFD_ADDR_W 4
`define UEFD_REG_ERR 4'h2
`define UEFD_REG_CTRL 4'h4
`define UEFD_BIT_PID 0
`define UEFD_BIT_TOKFRM 1
`define UEFD_BIT_DATA_CHECKSUM_FAILURE 2
`define UEFD_BIT_NONOCT 3
`define UEFD_BIT_BTO 4
`define UEFD_BIT_DMA 5
`define UEFD_BIT_STUFF 7
`define UEFD_VALID_MASK 8'hbf
`define UEFD_ERR_RESET 16'h0000
`define UEFD_BTO_LIMIT 16
`define UEFD_BIT_CLKS 2
`endif

// ==== src/uefd_pkg.sv ====
package uefd_pkg;
   // Per-packet receive checks reported by the serial decoder
   typedef struct packed {
      logic stuff_err;
      logic pid_bad;
      logic crc5_bad;
      logic data_checksum_failure_bad;
      logic non_octet;
   } uefd_rx_chk_t;
   // DMA events
   typedef struct packed {
      logic tx_need_no_grant;
      logic rx_need_no_grant;
      logic oversize;
   } uefd_dma_evt_t;
   typedef enum logic [1:0] {
      UEFD_TA_IDLE = 2'b00,
      UEFD_TA_WAIT = 2'b01
   } uefd_ta_state_t;
endpackage

// ==== src/uefd_error_flags.sv ====
`timescale 1ns/1ns
`include "uefd_params.svh"
module uefd_error_flags
   import uefd_pkg::*;
#(
   parameter int BTO_LIMIT = `UEFD_BTO_LIMIT,
   parameter int BIT_CLKS = `UEFD_BIT_CLKS
) (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic [`UEFD_ADDR_W-1:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   input wire logic EOP_I,
   input wire logic TA_START_I,
   input wire logic LINE_IDLE_I,
   input wire logic PKT_END_I,
   input wire logic TOKEN_PKT_I,
   input wire logic DATA_PKT_I,
   input wire uefd_rx_chk_t RX_CHK_I,
   input wire uefd_dma_evt_t DMA_EVT_I,
   input wire logic DATA_XFER_I,
   input wire logic SOF_CNT_ZERO_I,
   output logic HOST_MODE_O,
   output logic PKT_REJECT_O,
   output logic TRUNCATE_O,
   output logic ERROR_IRQ_O
);
   logic [7:0] err_en_q, err_en_d;
   logic [7:0] err_st_q, err_st_d;
   logic host_q, host_d;
   logic [15:0] rdata_q, rdata_d;
   logic [7:0] bt_cnt_q, bt_cnt_d;
   logic [7:0] clk_cnt_q, clk_cnt_d;
   logic idle_s1_q, idle_s2_q;
   uefd_ta_state_t ta_q, ta_d;
   logic [7:0] ev;
   logic [7:0] wr_clr;
   logic wr_err, wr_ctrl, bto_hit;

   assign wr_err = WR_I && (ADDR_I == `UEFD_REG_ERR);
   assign wr_ctrl = WR_I && (ADDR_I == `UEFD_REG_CTRL);

   // Line idle comes from the pins, so synchronise it first
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         // Reset to the idle level so no false activity follows reset
         idle_s1_q <= 1'b1;
         idle_s2_q <= 1'b1;
      end else begin
         idle_s1_q <= LINE_IDLE_I;
         idle_s2_q <= idle_s1_q;
      end
   end

   // Turnaround timer counts bit times from the previous EOP
   always_comb begin
      ta_d = ta_q;
      clk_cnt_d = clk_cnt_q;
      bt_cnt_d = bt_cnt_q;
      bto_hit = 1'b0;
      unique case (ta_q)
         UEFD_TA_IDLE: begin
            if (TA_START_I && EOP_I) begin
               ta_d = UEFD_TA_WAIT;
               clk_cnt_d = 8'h00;
               bt_cnt_d = 8'h00;
            end
         end
         UEFD_TA_WAIT: begin
            if (!idle_s2_q) begin
               ta_d = UEFD_TA_IDLE;
            end else if (clk_cnt_q == 8'(BIT_CLKS - 1)) begin
               clk_cnt_d = 8'h00;
               bt_cnt_d = bt_cnt_q + 8'h01;
               if (bt_cnt_q == 8'(BTO_LIMIT)) begin
                  bto_hit = 1'b1;
                  ta_d = UEFD_TA_IDLE;
               end
            end else begin
               clk_cnt_d = clk_cnt_q + 8'h01;
            end
         end
         default: ta_d = UEFD_TA_IDLE;
      endcase
   end

   assign ev[`UEFD_BIT_STUFF] = PKT_END_I && RX_CHK_I.stuff_err;
   assign ev[6] = 1'b0;
   assign ev[`UEFD_BIT_DMA] = DMA_EVT_I.tx_need_no_grant
      || DMA_EVT_I.rx_need_no_grant
      || DMA_EVT_I.oversize;
   assign ev[`UEFD_BIT_BTO] = bto_hit;
   assign ev[`UEFD_BIT_NONOCT] = PKT_END_I && DATA_PKT_I
      && RX_CHK_I.non_octet;
   assign ev[`UEFD_BIT_DATA_CHECKSUM_FAILURE] = PKT_END_I && DATA_PKT_I
      && RX_CHK_I.data_checksum_failure_bad;
   assign ev[`UEFD_BIT_TOKFRM] =
      (!host_q && PKT_END_I && TOKEN_PKT_I && RX_CHK_I.crc5_bad)
      || (host_q && DATA_XFER_I && SOF_CNT_ZERO_I);
   assign ev[`UEFD_BIT_PID] = PKT_END_I && RX_CHK_I.pid_bad;

   assign wr_clr = wr_err ? WDATA_I[7:0] : 8'h00;
   // Set wins over a same-cycle clear so no event is lost
   assign err_st_d = ((err_st_q & ~wr_clr) | ev)
      & `UEFD_VALID_MASK;
   assign err_en_d = wr_err ? (WDATA_I[15:8] & `UEFD_VALID_MASK)
      : err_en_q;
   assign host_d = wr_ctrl ? WDATA_I[0] : host_q;

   assign rdata_d = !RD_I ? 16'h0000 :
      (ADDR_I == `UEFD_REG_ERR) ? {err_en_q, err_st_q} :
      (ADDR_I == `UEFD_REG_CTRL) ? {15'h0000, host_q} : 16'h0000;

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         err_en_q <= 8'(`UEFD_ERR_RESET >> 8);
         err_st_q <= 8'h00;
         host_q <= 1'b0;
         rdata_q <= 16'h0000;
         ta_q <= UEFD_TA_IDLE;
         clk_cnt_q <= 8'h00;
         bt_cnt_q <= 8'h00;
      end else begin
         err_en_q <= err_en_d;
         err_st_q <= err_st_d;
         host_q <= host_d;
         rdata_q <= rdata_d;
         ta_q <= ta_d;
         clk_cnt_q <= clk_cnt_d;
         bt_cnt_q <= bt_cnt_d;
      end
   end

   assign RDATA_O = rdata_q;
   assign HOST_MODE_O = host_q;
   // Reject is combinational so the packet is dropped at its own end
   assign PKT_REJECT_O = ev[`UEFD_BIT_STUFF] || ev[`UEFD_BIT_DATA_CHECKSUM_FAILURE]
      || (!host_q && PKT_END_I && TOKEN_PKT_I && RX_CHK_I.crc5_bad);
   assign TRUNCATE_O = DMA_EVT_I.oversize;
   assign ERROR_IRQ_O = |(err_st_q & err_en_q);
endmodule

// ==== dv/uefd_usb_peer.sv ====
`timescale 1ns/1ns
module uefd_peer_model (
   input wire logic go_i,
   input wire logic resp_i,
   output logic eop_o,
   output logic ta_o,
   output logic idle_o
);
   assign eop_o = go_i;
   assign ta_o = go_i;
   // Line leaves idle only when the far side answers
   assign idle_o = !resp_i;
endmodule

// ==== dv/uefd_error_flags_checker.sv ====
`timescale 1ns/1ns
module uefd_error_flags_checker
   import uefd_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [15:0] RDATA_O,
   input wire logic PKT_END_I,
   input wire logic TOKEN_PKT_I,
   input wire logic DATA_PKT_I,
   input wire uefd_rx_chk_t RX_CHK_I,
   input wire uefd_dma_evt_t DMA_EVT_I,
   input wire logic HOST_MODE_O,
   input wire logic PKT_REJECT_O,
   input wire logic TRUNCATE_O,
   input wire logic ERROR_IRQ_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   stuff_rej_a: assert property (PKT_END_I && RX_CHK_I.stuff_err |->
      PKT_REJECT_O) else $error("stuff packet kept");
   data_checksum_failure_rej_a: assert property (PKT_END_I && DATA_PKT_I &&
      RX_CHK_I.data_checksum_failure_bad |-> PKT_REJECT_O) else $error("data_checksum_failure kept");
   crc5_rej_a: assert property (PKT_END_I && TOKEN_PKT_I &&
      RX_CHK_I.crc5_bad && !HOST_MODE_O |-> PKT_REJECT_O)
      else $error("crc5 kept");
   trunc_a: assert property (TRUNCATE_O == DMA_EVT_I.oversize)
      else $error("truncate wrong");
   rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0)
      else $error("read data not idle");
   irq_reset_a: assert property ($rose(NRST_I) |-> !ERROR_IRQ_O)
      else $error("irq after reset");
   host_write_a: assert property ($changed(HOST_MODE_O) |->
      $past(WR_I) && $past(ADDR_I) == 4'h4) else $error("host moved");
   irq_hold_a: assert property (ERROR_IRQ_O && !WR_I |=> ERROR_IRQ_O)
      else $error("irq dropped");
   cover property (ERROR_IRQ_O);
   cover property (PKT_REJECT_O);
   cover property (TRUNCATE_O);
endmodule
bind uefd_error_flags uefd_error_flags_checker i_chk (.*);

// ==== dv/usb_error_detect_flags_tb.sv ====
`timescale 1ns/1ns
module usb_error_detect_flags_tb import uefd_pkg::*;;
   logic CLOCK_I = 0, NRST_I = 0, WR_I = 0, RD_I = 0, PKT_END_I = 0;
   logic TOKEN_PKT_I = 0, DATA_PKT_I = 0, DATA_XFER_I = 0, SOF_CNT_ZERO_I = 0;
   logic go = 0, resp = 0, eop, ta, idle, host, irq, rej, tr;
   logic [3:0] ADDR_I = 0;
   logic [15:0] WDATA_I = 0, RDATA_O;
   uefd_rx_chk_t RX_CHK_I = '0;
   uefd_dma_evt_t DMA_EVT_I = '0;
   logic [7:0] st = 0, en = 0;
   logic [4:0] ck [8] = '{5'h08, 5'h04, 5'h02, 5'h01, 0, 0, 0, 5'h10};
   int failures = 0, n_tests = 0;
   uefd_peer_model i_uefd_peer_model (.go_i(go), .resp_i(resp),
      .eop_o(eop), .ta_o(ta), .idle_o(idle));
   uefd_error_flags i_uefd_error_flags (.CLOCK_I, .NRST_I, .ADDR_I,
      .WDATA_I, .WR_I, .RD_I, .RDATA_O, .EOP_I(eop), .TA_START_I(ta),
      .LINE_IDLE_I(idle), .PKT_END_I, .TOKEN_PKT_I, .DATA_PKT_I,
      .RX_CHK_I, .DMA_EVT_I, .DATA_XFER_I, .SOF_CNT_ZERO_I,
      .HOST_MODE_O(host), .PKT_REJECT_O(rej), .TRUNCATE_O(tr),
      .ERROR_IRQ_O(irq));
   initial begin
      forever #2 CLOCK_I = ~CLOCK_I;
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      ADDR_I <= a; RD_I <= 1;
      @(posedge CLOCK_I) RD_I <= 0;
      #1 chk(RDATA_O, e);
      chk({15'h0, irq}, {15'h0, |(st & en)});
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      ADDR_I <= a; WDATA_I <= d; WR_I <= 1;
      @(posedge CLOCK_I) WR_I <= 0;
      if (a == 4'h2) begin
         en = d[15:8] & 8'hbf;
         st &= ~d[7:0];
      end
   endtask
   task ev(input int b);
      if (b == 5) DMA_EVT_I <= 3'b001 << ($urandom % 3);
      else begin
         PKT_END_I <= 1; TOKEN_PKT_I <= b == 1; RX_CHK_I <= ck[b];
         DATA_PKT_I <= b == 2 || b == 3;
      end
      @(posedge CLOCK_I) PKT_END_I <= 0;
      DMA_EVT_I <= '0; RX_CHK_I <= '0; st[b] = 1;
      @(posedge CLOCK_I);
   endtask
   task bto(input int n, input bit s);
      go <= 1;
      @(posedge CLOCK_I) go <= 0;
      repeat (n) @(posedge CLOCK_I);
      resp <= 1;
      repeat (45) @(posedge CLOCK_I);
      resp <= 0; st[4] = s;
   endtask
   task final_report;
      if (failures == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #30000 failures++;
      final_report;
   end
   initial begin
      void'($urandom(32'hd8f6));
      repeat (10) @(posedge CLOCK_I);
      NRST_I <= 1;
      @(posedge CLOCK_I) rd(4'h2, 16'h0);
      wr(4'h2, 16'hffff); rd(4'h2, {en, st});
      for (int b = 0; b < 8; b++) if (b != 4 && b != 6) begin
         ev(b); rd(4'h2, {en, st});
      end
      wr(4'h2, {8'($urandom), 8'h00}); rd(4'h2, {en, st});
      wr(4'h2, {en, 8'hff}); bto(5, 0); rd(4'h2, {en, st});
      bto(44, 1); rd(4'h2, {en, st});
      wr(4'h4, 16'h1);
      #1 chk({15'h0, host}, 16'h1);
      DATA_XFER_I <= 1; SOF_CNT_ZERO_I <= 1;
      @(posedge CLOCK_I) DATA_XFER_I <= 0;
      @(posedge CLOCK_I) st[1] = 1; rd(4'h2, {en, st});
      rd(4'hf, 16'h0);
      final_report;
   end
endmodule
